// ### afpd_cfg.svh
// timing and format constants for the converter output control block
`ifndef AFPD_CFG_SVH
`define AFPD_CFG_SVH
`define AFPD_DATA_W        12
`define AFPD_FIFO_DEPTH    32
`define AFPD_PIPE_LAT      4'h7
`define AFPD_FMT_SETTLE    8'h04
`define AFPD_EXIT_NS       5000
`define AFPD_CLK_NS        40
`define AFPD_EXIT_CYC      ((`AFPD_EXIT_NS + `AFPD_CLK_NS - 1) / `AFPD_CLK_NS)
`define AFPD_SIGN_BIT      11
`endif

// ### afpd_pkg.sv
// types for the converter output control block
package afpd_pkg;
    typedef logic [11:0] afpd_word_t;
    typedef enum logic [2:0] {
        AFPD_SLEEP  = 3'b001,
        AFPD_WAKE   = 3'b010,
        AFPD_RUN    = 3'b100
    } afpd_state_e;
endpackage

// ### afpd_fifo.sv
// parameterised valid/ready fifo for the sample stream
`timescale 1ns/10ps
module afpd_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             flush
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != (AW+1)'(DEPTH)) && !flush;
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready && !flush;
    assign out_data  = mem[rd_ptr_r];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else if (flush)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // afpd_fifo

// ### afpd_core.sv
// converter digital side: format select, sleep handling, pipeline, output fifo
//
// Behaviour
// [R1] two's complement output when format_select high, offset binary when low
// [R2] format change makes a few following samples uncertain; marked invalid
// [R3] sleep_request high holds power-down with no conversions
// [R4] power-down held without relying on clock edges; only data_oe_n and run follow the pin unclocked, the state needs an edge
// [R5] in power-down output word undefined and pipeline contents lost
// [R6] after sleep exit conversions inaccurate until reference recharged
// [R7] each result is a parallel twelve-bit word
// [R8] data driven on outputs only while sleep_request low
// [R9] capture logic registers output on rising conversion clock edge
// [R10] clock sets sampling and advances sequencer, one word per cycle
// [R11] samples delayed a fixed parameterised number of cycles through pipeline
// [R12] samples marked invalid for parameterised cycles after exit or format change
`timescale 1ns/10ps
`include "afpd_cfg.svh"
module afpd_core
    import afpd_pkg::*;
#(
    parameter int EXIT_CYC = `AFPD_EXIT_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    sleep_request,
    input  wire logic                    format_select,
    input  wire logic [`AFPD_DATA_W-1:0] sample_in,
    output logic      [`AFPD_DATA_W-1:0] data_out,
    output logic                         data_oe_n,
    output logic                         data_valid,
    input  wire logic                    data_ready,
    output logic                         powered_down,
    output logic                         overflow
);
    localparam int LAT = `AFPD_PIPE_LAT;

    logic        sleep_s1_r;
    logic        sleep_s2_r;
    logic        fmt_s1_r;
    logic        fmt_s2_r;
    logic        fmt_d_r;
    logic        sleep_async;
    afpd_state_e state_r;
    afpd_state_e state_nxt;
    logic [15:0] wait_r;
    logic [7:0]  fmt_hold_r;
    afpd_word_t  pipe_r [LAT];
    logic        pvld_r [LAT];
    afpd_word_t  conv_word;
    logic        run;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    afpd_word_t  fifo_out_data;
    logic        flush;

    // async level drives data_oe_n even with a stopped clock; the state enters sleep on the next edge
    assign sleep_async = sleep_request; // [R4]

    // sleep syncs reset high so power-down holds over reset release
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sleep_s1_r <= 1'b1;
            sleep_s2_r <= 1'b1;
            fmt_s1_r   <= 1'b0;
            fmt_s2_r   <= 1'b0;
            fmt_d_r    <= 1'b0;
        end
        else
        begin
            sleep_s1_r <= sleep_request;
            sleep_s2_r <= sleep_s1_r;
            fmt_s1_r   <= format_select;
            fmt_s2_r   <= fmt_s1_r;
            fmt_d_r    <= fmt_s2_r;
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            AFPD_SLEEP:
                if (!sleep_s2_r)
                    state_nxt = AFPD_WAKE;
            AFPD_WAKE:
                if (sleep_s2_r)
                    state_nxt = AFPD_SLEEP;
                else if (wait_r == 16'h0001)
                    state_nxt = AFPD_RUN; // [R6]
            AFPD_RUN:
                if (sleep_s2_r)
                    state_nxt = AFPD_SLEEP; // [R3]
            default:
                state_nxt = AFPD_SLEEP;
        endcase
    end

    // raw pin forces sleep; with a stopped clock data_oe_n still follows it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_r <= AFPD_SLEEP;
        else if (sleep_async)
            state_r <= AFPD_SLEEP; // [R4]
        else
            state_r <= state_nxt;
    end

    // exit wait stands in for reference recharge; its length is a parameter
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wait_r <= 16'h0000;
        else if (state_r != AFPD_WAKE)
            wait_r <= 16'(EXIT_CYC); // [R12]
        else if (wait_r != 16'h0000)
            wait_r <= wait_r - 16'h0001;
    end

    // a format flip keeps output invalid for a settle window
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            fmt_hold_r <= 8'h00;
        else if (fmt_s2_r != fmt_d_r)
            fmt_hold_r <= `AFPD_FMT_SETTLE; // [R2]
        else if (fmt_hold_r != 8'h00)
            fmt_hold_r <= fmt_hold_r - 8'h01;
    end

    assign run   = (state_r == AFPD_RUN) && !sleep_async; // [R10]
    assign flush = (state_r == AFPD_SLEEP); // [R5]

    // raw sample treated as offset binary; msb flip gives two's complement
    assign conv_word = fmt_s2_r ? {~sample_in[`AFPD_SIGN_BIT], sample_in[`AFPD_SIGN_BIT-1:0]}
                                : sample_in; // [R1]

    // whole pipeline stalls with the fifo, so no middle stage is overwritten
    genvar g;
    generate
        for (g = 0; g < LAT; g++)
        begin : g_pipe
            if (g == 0)
            begin : g_head
                always_ff @(posedge clk or negedge nrst)
                begin
                    if (!nrst)
                    begin
                        pipe_r[g] <= '0;
                        pvld_r[g] <= 1'b0;
                    end
                    else if (flush)
                        pvld_r[g] <= 1'b0; // [R5]
                    else if (fifo_in_ready)
                    begin
                        pipe_r[g] <= conv_word;
                        pvld_r[g] <= run && (fmt_hold_r == 8'h00); // [R12]
                    end
                end
            end
            else
            begin : g_tail
                always_ff @(posedge clk or negedge nrst)
                begin
                    if (!nrst)
                    begin
                        pipe_r[g] <= '0;
                        pvld_r[g] <= 1'b0;
                    end
                    else if (flush)
                        pvld_r[g] <= 1'b0; // [R5]
                    else if (fifo_in_ready)
                    begin
                        pipe_r[g] <= pipe_r[g-1];
                        pvld_r[g] <= pvld_r[g-1]; // [R11]
                    end
                end
            end
        end
    endgenerate

    // pipeline stalls on a full fifo, so new samples are dropped at its head and overflow flags it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            overflow <= 1'b0;
        else if (flush)
            overflow <= 1'b0;
        else if (pvld_r[LAT-1] && !fifo_in_ready)
            overflow <= 1'b1;
    end

    afpd_fifo #(
        .WIDTH (`AFPD_DATA_W),
        .DEPTH (`AFPD_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (pvld_r[LAT-1]),
        .in_ready  (fifo_in_ready),
        .in_data   (pipe_r[LAT-1]),
        .out_valid (fifo_out_valid),
        .out_ready (data_ready),
        .out_data  (fifo_out_data),
        .flush     (flush)
    );

    // registered copy of the fifo head, so it trails each pop by one edge
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            data_out <= '0;
        else if (!flush)
            data_out <= fifo_out_data; // [R7]
    end

    assign data_valid   = fifo_out_valid && !flush; // [R9]
    assign data_oe_n    = sleep_async || flush; // [R8]
    assign powered_down = flush;
endmodule // afpd_core

// ### afpd_props.sv
// assertion checker for the converter output control block
`timescale 1ns/10ps
module afpd_props #(
    parameter int EXIT_CYC = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sleep_request,
    input wire logic data_valid,
    input wire logic data_ready,
    input wire logic data_oe_n,
    input wire logic powered_down,
    input wire logic overflow
);
    // sync, exit wait, pipe and fifo, with slack
    localparam int WAKE_MAX = EXIT_CYC + 20;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_oe_sleep; sleep_request |-> data_oe_n; endproperty
    property p_oe_run; !sleep_request && !powered_down |-> !data_oe_n; endproperty
    property p_sleep_next; sleep_request |=> powered_down; endproperty
    property p_pd_oe; powered_down |-> data_oe_n; endproperty
    property p_flush; powered_down && $past(powered_down) |-> !data_valid; endproperty
    property p_ovf_clr; powered_down && $past(powered_down) |-> !overflow; endproperty
    property p_hold; data_valid && !data_ready && !sleep_request && !powered_down |=> data_valid || powered_down;
    endproperty
    property p_wake_quiet; $fell(powered_down) |-> !data_valid [*8]; endproperty
    property p_wake_bound; $fell(powered_down) |-> ##[1:WAKE_MAX] (data_valid || sleep_request); endproperty
    a_oe_sleep: assert property (p_oe_sleep) else $error("outputs driven in sleep");
    a_oe_run: assert property (p_oe_run) else $error("outputs not driven in run");
    a_sleep_next: assert property (p_sleep_next) else $error("sleep not entered");
    a_pd_oe: assert property (p_pd_oe) else $error("outputs driven in power-down");
    a_flush: assert property (p_flush) else $error("valid word in power-down");
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow kept in power-down");
    a_hold: assert property (p_hold) else $error("valid dropped while stalled");
    a_wake_quiet: assert property (p_wake_quiet) else $error("valid too soon after wake");
    a_wake_bound: assert property (p_wake_bound) else $error("no word after wake");
    c_pop: cover property (data_valid && data_ready);
    c_wake: cover property ($fell(powered_down));
    c_ovf: cover property (overflow);
endmodule // afpd_props

bind afpd_core afpd_props #(.EXIT_CYC(EXIT_CYC)) u_props (.clk(clk), .nrst(nrst), .sleep_request(sleep_request),
    .data_valid(data_valid), .data_ready(data_ready), .data_oe_n(data_oe_n), .powered_down(powered_down),
    .overflow(overflow));

// ### afpd_capture.sv
// capture logic model latching the sample word on the conversion clock
`timescale 1ns/10ps
module afpd_capture #(
    parameter int GUARD = 16
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        stall_en,
    input  wire logic        format_select,
    input  wire logic [11:0] data_out,
    input  wire logic        data_oe_n,
    input  wire logic        data_valid,
    output logic             data_ready,
    output logic             cap_stb,
    output logic      [11:0] cap_word
);
    logic [3:0] lfsr_r;
    logic       pop_d_r;
    logic       fmt_last_r;
    logic [7:0] guard_r;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lfsr_r <= 4'h1;
            pop_d_r <= 1'b0;
            fmt_last_r <= 1'b0;
            guard_r <= 8'(GUARD);
            data_ready <= 1'b0;
            cap_stb <= 1'b0;
            cap_word <= 12'h000;
        end
        else
        begin
            lfsr_r <= {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]};
            pop_d_r <= data_valid && data_ready;
            fmt_last_r <= format_select;
            data_ready <= !(stall_en && lfsr_r[0]);
            // discard window after wake or a format flip covers words still in flight
            if (data_oe_n || (format_select != fmt_last_r))
                guard_r <= 8'(GUARD);
            else if (guard_r != 8'h00)
                guard_r <= guard_r - 8'h01;
            // output word trails the pop by one edge, so strobe on the delayed pop
            cap_stb <= pop_d_r && !data_oe_n && guard_r == 8'h00 && format_select == fmt_last_r;
            cap_word <= data_out;
        end
    end
endmodule // afpd_capture

// ### afpd_core_tb.sv
// self-checking bench for the converter output control block
`timescale 1ns/10ps
module afpd_core_tb;
    import afpd_pkg::*;
    logic        clk, nrst, sleep_request, format_select, stall_en;
    logic [11:0] sample_in, data_out, cap_word;
    logic        data_oe_n, data_valid, data_ready, powered_down, overflow, cap_stb;
    int          mismatches, n_tests, n_cap, exp_w, seed;
    int          vals[$] = '{0, 0, 4095, 4095, 0, 0};
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    afpd_core #(.EXIT_CYC(4)) dut (.clk(clk), .nrst(nrst), .sleep_request(sleep_request),
        .format_select(format_select), .sample_in(sample_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_valid(data_valid), .data_ready(data_ready), .powered_down(powered_down), .overflow(overflow));
    afpd_capture u_cap (.clk(clk), .nrst(nrst), .stall_en(stall_en), .format_select(format_select),
        .data_out(data_out), .data_oe_n(data_oe_n), .data_valid(data_valid), .data_ready(data_ready),
        .cap_stb(cap_stb), .cap_word(cap_word));
    task automatic check(input string what, input afpd_word_t seen, input afpd_word_t exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(negedge clk)
        if (cap_stb === 1'b1)
        begin
            check("word", cap_word, 12'(exp_w));
            n_cap++;
        end
    initial
    begin
        #(40 * 8000);
        mismatches++;
        test_done();
    end
    initial
    begin
        seed = 32'h7306;
        mismatches = 0;
        n_tests = 0;
        n_cap = 0;
        exp_w = 0;
        {nrst, sleep_request, format_select, stall_en} = 4'h4;
        sample_in = 12'h000;
        vals[4] = $random(seed) & 4095;
        vals[5] = $random(seed) & 4095;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        // each wake starts with the format set during sleep
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            sleep_request <= 1'b1;
            format_select <= i[0];
            sample_in <= 12'(vals[i]);
            stall_en <= i[1];
            repeat (8) @(negedge clk);
            check("oe_n", 12'(data_oe_n), 12'h001);
            check("powered_down", 12'(powered_down), 12'h001);
            check("valid", 12'(data_valid), 12'h000);
            check("overflow", 12'(overflow), 12'h000);
            exp_w = i[0] ? (vals[i] + 2048) % 4096 : vals[i];
            n_cap = 0;
            @(posedge clk);
            sleep_request <= 1'b0;
            for (int t = 0; t < (i[1] ? 500 : 140) && n_cap < 100; t++)
                @(negedge clk);
            check("captures", 12'(n_cap >= 100), 12'h001);
            check("oe_n run", 12'(data_oe_n), 12'h000);
            check("overflow run", 12'(overflow), 12'(i[1]));
            if (i[1] == 1'b0)
            begin
                // flip format while converting; the capture guard drops the mixed words
                @(posedge clk);
                format_select <= ~i[0];
                @(posedge clk);
                exp_w = i[0] ? vals[i] : (vals[i] + 2048) % 4096;
                n_cap = 0;
                for (int t = 0; t < 80 && n_cap < 20; t++)
                    @(negedge clk);
                check("fmt captures", 12'(n_cap >= 20), 12'h001);
            end
        end
        test_done();
    end
endmodule // afpd_core_tb
